// file: inc/rsc_regs.svh
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// timing
`define RSC_CLK_KHZ 20000
`define RSC_SLOW_OSC_KHZ 240
`define RSC_SLOW_DIV ((`RSC_CLK_KHZ) / (`RSC_SLOW_OSC_KHZ))
`define RSC_HOLD_TICKS 21
`define RSC_EXT_MIN_NS 10000
`define RSC_EXT_MIN_CYC (((`RSC_EXT_MIN_NS) * (`RSC_CLK_KHZ) + 999999) / 1000000)

// reset vector
`define RSC_VEC_LO 16'h0000
`define RSC_VEC_HI 16'h0001

// register byte offsets
`define RSC_OFS_CAUSE 12'h000
`define RSC_OFS_LVD 12'h004
`define RSC_OFS_SETTLE 12'h008
`define RSC_OFS_CLKCTL 12'h00c
`define RSC_OFS_STATUS 12'h010

// fields
`define RSC_CAUSE_WDT_BIT 4
`define RSC_CAUSE_LVD_BIT 0
`define RSC_CLKCTL_HS_BIT 0

// reset values
`define RSC_LVD_RST 8'h00
`define RSC_SETTLE_RST 8'h05
`define RSC_PORT_LATCH_RST 8'h00
`define RSC_PULLUP_RST 8'h00
`define RSC_INV_CMP_RST 10'h000
`define RSC_INV_CMP3_RST 10'h0ff
`define RSC_INV_DEAD_RST 8'hff
`define RSC_WIDE_RST 16'h0000

`endif

// file: inc/rsc_pkg.sv
package rsc_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_RESET,
    ST_HOLD,
    ST_VECTOR
  } rsc_state_t;

  typedef struct packed {
    logic ext;
    logic power_on_clear_detector;
    logic wdt;
    logic lvd;
  } rsc_src_t;

  // values loaded into the peripherals while the internal reset stands, except in standby
  typedef struct packed {
    logic [7:0] port_latch_zero;
    logic [7:0] port_latch_one;
    logic [7:0] port_latch_five;
    logic [7:0] pullup_option_port_zero;
    logic [7:0] pullup_option_port_one;
    logic [7:0] pullup_option_port_five;
    logic [9:0] inverter_timer_compare_other;
    logic [9:0] inverter_timer_compare_three;
    logic [7:0] inverter_dead_time_reload;
    logic [15:0] wide_timer_count;
    logic [15:0] wide_timer_capture_compare_zero;
    logic [15:0] wide_timer_capture_compare_one;
  } rsc_init_t;

endpackage : rsc_pkg

// file: hdl/rsc_reset_source_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"

module rsc_reset_source_controller #(
  parameter int SLOW_DIV = `RSC_SLOW_DIV,
  parameter int HOLD_TICKS = `RSC_HOLD_TICKS
) (
  // clock and block reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // reset sources and stop mode
  input wire logic RESET_PIN_N_IN,
  input wire logic POC_DETECT_IN,
  input wire logic WDT_OVERFLOW_IN,
  input wire logic LVD_DETECT_IN,
  input wire logic STOP_MODE_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // reset and clock control
  output logic SYS_RESET_N_OUT,
  output logic CPU_CLK_EN_OUT,
  output logic CPU_ON_SLOW_OSC_OUT,
  output logic SLOW_OSC_RUN_OUT,
  output logic XTAL_OSC_RUN_OUT,
  output logic PORT_HIZ_OUT,
  // peripheral side effects
  output logic WDT_REINIT_OUT,
  output logic LVD_CIRCUIT_RESET_OUT,
  output logic STANDBY_HOLD_OUT,
  output logic PERIPH_INIT_OUT,
  output rsc_pkg::rsc_init_t INIT_VALUES_OUT,
  output logic [7:0] LVD_SETTINGS_OUT,
  output logic [7:0] SETTLE_SEL_OUT,
  // vector fetch
  output logic VECTOR_FETCH_OUT,
  output logic [15:0] VECTOR_ADDR_OUT
);

  generate
    if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin : g_bad_div
      $error("SLOW_DIV must lie in 2..65535");
    end
    if (HOLD_TICKS < 1 || HOLD_TICKS > 31) begin : g_bad_hold
      $error("HOLD_TICKS must lie in 1..31");
    end
  endgenerate

  localparam logic [15:0] DIV_LAST = 16'(SLOW_DIV - 1);
  localparam logic [4:0] HOLD_LAST = 5'(HOLD_TICKS - 1);

  // register selector, shared by the read and write paths
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    unique case (addr)
      `RSC_OFS_CAUSE: reg_sel = 3'h1;
      `RSC_OFS_LVD: reg_sel = 3'h2;
      `RSC_OFS_SETTLE: reg_sel = 3'h3;
      `RSC_OFS_CLKCTL: reg_sel = 3'h4;
      `RSC_OFS_STATUS: reg_sel = 3'h5;
      default: reg_sel = 3'h0;
    endcase
  endfunction : reg_sel

  // pin synchroniser
  logic pin_meta, pin_sync;
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= RESET_PIN_N_IN;
      pin_sync <= pin_meta;
    end
  end

  rsc_pkg::rsc_src_t src;
  logic src_act;
  always_comb begin
    src.ext = !pin_sync;
    src.power_on_clear_detector = POC_DETECT_IN;
    src.wdt = WDT_OVERFLOW_IN;
    src.lvd = LVD_DETECT_IN;
    src_act = src.ext | src.power_on_clear_detector | src.wdt | src.lvd;
  end

  // sequencer
  rsc_pkg::rsc_state_t state;
  rsc_pkg::rsc_state_t next_state;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [4:0] tick_cnt;
  logic [4:0] next_tick_cnt;
  logic standby;
  logic next_standby;
  logic slow_tick;

  always_comb begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_tick_cnt = tick_cnt;
    next_standby = standby;
    // slow oscillator is frozen while the pin holds reset
    slow_tick = !src.ext && (div_cnt == DIV_LAST);
    if (src.ext) begin
      next_div_cnt = 16'h0000;
    end else if (slow_tick) begin
      next_div_cnt = 16'h0000;
    end else begin
      next_div_cnt = div_cnt + 16'h0001;
    end
    if (src_act) begin
      // every source lands in the same state; flags, oscillators and lvd settings still differ by source
      next_state = rsc_pkg::ST_RESET;
      next_tick_cnt = 5'h00;
      if (state != rsc_pkg::ST_RESET) begin
        next_standby = STOP_MODE_IN;
      end
    end else begin
      unique case (state)
        rsc_pkg::ST_RUN: begin
          next_standby = 1'b0;
        end
        rsc_pkg::ST_RESET: begin
          // pin high, watchdog pulse gone, or supply recovered
          next_state = rsc_pkg::ST_HOLD;
          next_div_cnt = 16'h0000;
          next_tick_cnt = 5'h00;
        end
        rsc_pkg::ST_HOLD: begin
          if (slow_tick) begin
            if (tick_cnt == HOLD_LAST) begin
              next_state = rsc_pkg::ST_VECTOR;
            end else begin
              next_tick_cnt = tick_cnt + 5'h01;
            end
          end
        end
        rsc_pkg::ST_VECTOR: begin
          next_state = rsc_pkg::ST_RUN;
          next_standby = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      state <= rsc_pkg::ST_RESET;
      div_cnt <= 16'h0000;
      tick_cnt <= 5'h00;
      standby <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      standby <= next_standby;
    end
  end

  // software registers
  logic apb_done, apb_wr, apb_rd;
  logic [2:0] sel;
  logic wdt_flag;
  logic next_wdt_flag;
  logic lvd_flag;
  logic next_lvd_flag;
  logic [7:0] lvd_set;
  logic [7:0] next_lvd_set;
  logic [7:0] settle_sel;
  logic [7:0] next_settle_sel;
  logic clk_hs;
  logic next_clk_hs;

  always_comb begin
    apb_done = PSEL_IN && PENABLE_IN && PREADY_OUT;
    apb_wr = apb_done && PWRITE_IN;
    apb_rd = apb_done && !PWRITE_IN;
    sel = reg_sel(PADDR_IN);
    next_wdt_flag = wdt_flag;
    next_lvd_flag = lvd_flag;
    next_lvd_set = lvd_set;
    next_settle_sel = settle_sel;
    next_clk_hs = clk_hs;
    // a read clears the flags, but a cause seen in the same cycle survives
    if (apb_rd && sel == 3'h1) begin
      next_wdt_flag = 1'b0;
      next_lvd_flag = 1'b0;
    end
    if (src.ext || src.power_on_clear_detector) begin
      next_wdt_flag = 1'b0;
      next_lvd_flag = 1'b0;
    end else begin
      if (src.wdt) begin
        next_wdt_flag = 1'b1;
      end
      if (src.lvd) begin
        next_lvd_flag = 1'b1;
      end
    end
    if (src.ext || src.power_on_clear_detector || src.wdt) begin
      next_lvd_set = `RSC_LVD_RST;
    end else if (!src.lvd && apb_wr && sel == 3'h2) begin
      next_lvd_set = PWDATA_IN[7:0];
    end
    if (src_act) begin
      next_settle_sel = `RSC_SETTLE_RST;
      next_clk_hs = 1'b0;
    end else if (apb_wr && sel == 3'h3) begin
      next_settle_sel = PWDATA_IN[7:0];
    end else if (apb_wr && sel == 3'h4) begin
      next_clk_hs = PWDATA_IN[`RSC_CLKCTL_HS_BIT];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      wdt_flag <= 1'b0;
      lvd_flag <= 1'b0;
      lvd_set <= `RSC_LVD_RST;
      settle_sel <= `RSC_SETTLE_RST;
      clk_hs <= 1'b0;
    end else begin
      wdt_flag <= next_wdt_flag;
      lvd_flag <= next_lvd_flag;
      lvd_set <= next_lvd_set;
      settle_sel <= next_settle_sel;
      clk_hs <= next_clk_hs;
    end
  end

  // apb answer: one wait state, read data captured with pready
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  always_comb begin
    next_pready = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_pslverr = (sel == 3'h0);
      if (!PWRITE_IN) begin
        unique case (sel)
          3'h1: begin
            next_prdata[`RSC_CAUSE_WDT_BIT] = wdt_flag;
            next_prdata[`RSC_CAUSE_LVD_BIT] = lvd_flag;
          end
          3'h2: next_prdata[7:0] = lvd_set;
          3'h3: next_prdata[7:0] = settle_sel;
          3'h4: next_prdata[`RSC_CLKCTL_HS_BIT] = clk_hs;
          3'h5: next_prdata[7:0] = {standby, tick_cnt, state};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= next_pready;
      PRDATA_OUT <= next_prdata;
      PSLVERR_OUT <= next_pslverr;
    end
  end

  // registered outputs, the state and register ones taken from next values so they track the state
  logic nxt_rst, nxt_hold;
  rsc_pkg::rsc_init_t init_vals;

  always_comb begin
    nxt_rst = (next_state == rsc_pkg::ST_RESET);
    nxt_hold = (next_state == rsc_pkg::ST_HOLD);
    init_vals.port_latch_zero = `RSC_PORT_LATCH_RST;
    init_vals.port_latch_one = `RSC_PORT_LATCH_RST;
    init_vals.port_latch_five = `RSC_PORT_LATCH_RST;
    init_vals.pullup_option_port_zero = `RSC_PULLUP_RST;
    init_vals.pullup_option_port_one = `RSC_PULLUP_RST;
    init_vals.pullup_option_port_five = `RSC_PULLUP_RST;
    init_vals.inverter_timer_compare_other = `RSC_INV_CMP_RST;
    init_vals.inverter_timer_compare_three = `RSC_INV_CMP3_RST;
    init_vals.inverter_dead_time_reload = `RSC_INV_DEAD_RST;
    init_vals.wide_timer_count = `RSC_WIDE_RST;
    init_vals.wide_timer_capture_compare_zero = `RSC_WIDE_RST;
    init_vals.wide_timer_capture_compare_one = `RSC_WIDE_RST;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      SYS_RESET_N_OUT <= 1'b0;
      CPU_CLK_EN_OUT <= 1'b0;
      CPU_ON_SLOW_OSC_OUT <= 1'b1;
      SLOW_OSC_RUN_OUT <= 1'b0;
      XTAL_OSC_RUN_OUT <= 1'b0;
      PORT_HIZ_OUT <= 1'b1;
      WDT_REINIT_OUT <= 1'b0;
      LVD_CIRCUIT_RESET_OUT <= 1'b1;
      STANDBY_HOLD_OUT <= 1'b0;
      PERIPH_INIT_OUT <= 1'b1;
      INIT_VALUES_OUT <= init_vals;
      LVD_SETTINGS_OUT <= `RSC_LVD_RST;
      SETTLE_SEL_OUT <= `RSC_SETTLE_RST;
      VECTOR_FETCH_OUT <= 1'b0;
      VECTOR_ADDR_OUT <= `RSC_VEC_LO;
    end else begin
      SYS_RESET_N_OUT <= !nxt_rst;
      CPU_CLK_EN_OUT <= !(nxt_rst || nxt_hold);
      CPU_ON_SLOW_OSC_OUT <= !next_clk_hs;
      SLOW_OSC_RUN_OUT <= !src.ext;
      XTAL_OSC_RUN_OUT <= !src.ext;
      PORT_HIZ_OUT <= nxt_rst || nxt_hold;
      WDT_REINIT_OUT <= src.wdt;
      // the detector only resets for the other causes
      LVD_CIRCUIT_RESET_OUT <= src.ext || src.power_on_clear_detector || src.wdt;
      STANDBY_HOLD_OUT <= nxt_rst && next_standby;
      // init values stay driven; the strobe is withheld in standby
      PERIPH_INIT_OUT <= nxt_rst && !next_standby;
      INIT_VALUES_OUT <= init_vals;
      LVD_SETTINGS_OUT <= next_lvd_set;
      SETTLE_SEL_OUT <= next_settle_sel;
      // stack pointer is not touched here and stays undefined
      VECTOR_FETCH_OUT <= (next_state == rsc_pkg::ST_VECTOR);
      VECTOR_ADDR_OUT <= `RSC_VEC_LO;
    end
  end

endmodule : rsc_reset_source_controller
`default_nettype wire

// file: bench/rsc_reset_source_controller_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"

module rsc_reset_source_controller_sva #(
  parameter int SLOW_DIV = `RSC_SLOW_DIV,
  parameter int HOLD_TICKS = `RSC_HOLD_TICKS
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // sources
  input wire logic RESET_PIN_N_IN,
  input wire logic POC_DETECT_IN,
  input wire logic WDT_OVERFLOW_IN,
  input wire logic LVD_DETECT_IN,
  // outputs watched
  input wire logic SYS_RESET_N_OUT,
  input wire logic CPU_CLK_EN_OUT,
  input wire logic SLOW_OSC_RUN_OUT,
  input wire logic XTAL_OSC_RUN_OUT,
  input wire logic PORT_HIZ_OUT,
  input wire logic WDT_REINIT_OUT,
  input wire logic LVD_CIRCUIT_RESET_OUT,
  input wire logic STANDBY_HOLD_OUT,
  input wire logic PERIPH_INIT_OUT,
  input wire rsc_pkg::rsc_init_t INIT_VALUES_OUT,
  input wire logic VECTOR_FETCH_OUT,
  input wire logic [15:0] VECTOR_ADDR_OUT
);
  localparam rsc_pkg::rsc_init_t INIT_EXP = {48'h0, 10'h000, 10'h0ff, 8'hff, 48'h0};
  // cycles since system reset released; a restart in hold zeroes it
  int hold_cnt;
  int next_hold_cnt;
  always_comb next_hold_cnt = (!RESET_N_IN || !SYS_RESET_N_OUT) ? 0 : hold_cnt + 1;
  always_ff @(posedge CLK_IN) hold_cnt <= next_hold_cnt;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_src_forces_reset: assert property ((POC_DETECT_IN || WDT_OVERFLOW_IN || LVD_DETECT_IN) |=>
    !SYS_RESET_N_OUT) else $error("source left reset high");
  a_pin_sync_reset: assert property (!RESET_PIN_N_IN [*3] |=> !SYS_RESET_N_OUT)
    else $error("pin low left reset high");
  a_hiz_with_hold: assert property (PORT_HIZ_OUT == !CPU_CLK_EN_OUT)
    else $error("ports not floating while clock held");
  a_hold_length: assert property (VECTOR_FETCH_OUT |-> hold_cnt == HOLD_TICKS * SLOW_DIV)
    else $error("clock hold length wrong");
  a_clk_held: assert property ($rose(SYS_RESET_N_OUT) |-> !CPU_CLK_EN_OUT [*8])
    else $error("clock ran right after release");
  a_fetch_vector: assert property (VECTOR_FETCH_OUT |-> (CPU_CLK_EN_OUT &&
    VECTOR_ADDR_OUT == 16'h0000) ##1 !VECTOR_FETCH_OUT) else $error("bad vector fetch");
  a_osc_stopped: assert property (!RESET_PIN_N_IN [*4] |-> !SLOW_OSC_RUN_OUT &&
    !XTAL_OSC_RUN_OUT) else $error("oscillator ran in pin reset");
  a_standby_kept: assert property (STANDBY_HOLD_OUT |-> PORT_HIZ_OUT && !PERIPH_INIT_OUT)
    else $error("standby contents not kept");
  a_lvd_spared: assert property ((RESET_PIN_N_IN && !POC_DETECT_IN &&
    !WDT_OVERFLOW_IN) [*3] |=> !LVD_CIRCUIT_RESET_OUT) else $error("detector reset itself");
  a_wdt_reinit: assert property (WDT_OVERFLOW_IN |=> WDT_REINIT_OUT)
    else $error("watchdog not reinitialised");
  a_init_values: assert property (PERIPH_INIT_OUT |-> INIT_VALUES_OUT == INIT_EXP)
    else $error("peripheral reset values wrong");
endmodule : rsc_reset_source_controller_sva

bind rsc_reset_source_controller rsc_reset_source_controller_sva #(
  .SLOW_DIV(SLOW_DIV), .HOLD_TICKS(HOLD_TICKS)) chk_u (.CLK_IN(CLK_IN),
  .RESET_N_IN(RESET_N_IN), .RESET_PIN_N_IN(RESET_PIN_N_IN), .POC_DETECT_IN(POC_DETECT_IN),
  .WDT_OVERFLOW_IN(WDT_OVERFLOW_IN), .LVD_DETECT_IN(LVD_DETECT_IN),
  .SYS_RESET_N_OUT(SYS_RESET_N_OUT), .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
  .SLOW_OSC_RUN_OUT(SLOW_OSC_RUN_OUT), .XTAL_OSC_RUN_OUT(XTAL_OSC_RUN_OUT),
  .PORT_HIZ_OUT(PORT_HIZ_OUT), .WDT_REINIT_OUT(WDT_REINIT_OUT),
  .LVD_CIRCUIT_RESET_OUT(LVD_CIRCUIT_RESET_OUT), .STANDBY_HOLD_OUT(STANDBY_HOLD_OUT),
  .PERIPH_INIT_OUT(PERIPH_INIT_OUT), .INIT_VALUES_OUT(INIT_VALUES_OUT),
  .VECTOR_FETCH_OUT(VECTOR_FETCH_OUT), .VECTOR_ADDR_OUT(VECTOR_ADDR_OUT));

`default_nettype wire

// file: bench/rsc_supply_model.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_supply_model #(
  parameter int EXT_MIN = 200
) (
  // clock
  input wire logic clk_in,
  // requests towards the block
  output logic pin_n_out,
  output logic poc_out,
  output logic wdt_out,
  output logic lvd_out
);
  initial {pin_n_out, poc_out, wdt_out, lvd_out} = 4'h8;

  // 0 pin, 1 power-on clear, 2 watchdog, 3 low voltage
  task automatic fire(input int src, input int len);
    int n;
    n = (src == 0 && len < EXT_MIN) ? EXT_MIN : len;
    @(posedge clk_in);
    pin_n_out <= (src != 0);
    poc_out <= (src == 1);
    wdt_out <= (src == 2);
    lvd_out <= (src == 3);
    repeat (n) @(posedge clk_in);
    {pin_n_out, poc_out, wdt_out, lvd_out} <= 4'h8;
  endtask : fire
endmodule : rsc_supply_model

`default_nettype wire

// file: bench/rsc_reset_source_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_source_controller_tb;
  typedef struct packed {
    logic [1:0] src;
    logic rd;
    logic [7:0] cause;
    logic [7:0] lvd;
  } rsc_row_t;
  rsc_row_t rows[8] = '{'{2, 0, 0, 0}, '{3, 1, 8'h11, 8'h5a}, '{2, 1, 8'h10, 0},
    '{3, 0, 0, 8'h5a}, '{1, 1, 0, 0}, '{3, 0, 0, 8'h5a}, '{0, 1, 0, 0}, '{3, 1, 8'h01, 8'h5a}};
  logic clk = 0, rst_n = 0, stop = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic prdy, perr, er, sysn, clken, onslow, hiz, sb, pinit, vf;
  logic [7:0] lvdo, settle;
  wire logic pin_n, power_on_clear_detector, wdt, lvd;
  int err_total = 0, checks = 0;

  always #25 clk = ~clk;

  rsc_supply_model sup_u (.clk_in(clk), .pin_n_out(pin_n), .poc_out(power_on_clear_detector), .wdt_out(wdt),
    .lvd_out(lvd));
  rsc_reset_source_controller #(.SLOW_DIV(2)) dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .RESET_PIN_N_IN(pin_n), .POC_DETECT_IN(power_on_clear_detector), .WDT_OVERFLOW_IN(wdt), .LVD_DETECT_IN(lvd),
    .STOP_MODE_IN(stop), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
    .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .SYS_RESET_N_OUT(sysn), .CPU_CLK_EN_OUT(clken), .CPU_ON_SLOW_OSC_OUT(onslow),
    .SLOW_OSC_RUN_OUT(), .XTAL_OSC_RUN_OUT(), .PORT_HIZ_OUT(hiz), .WDT_REINIT_OUT(),
    .LVD_CIRCUIT_RESET_OUT(), .STANDBY_HOLD_OUT(sb), .PERIPH_INIT_OUT(pinit),
    .INIT_VALUES_OUT(), .LVD_SETTINGS_OUT(lvdo), .SETTLE_SEL_OUT(settle), .VECTOR_FETCH_OUT(vf),
    .VECTOR_ADDR_OUT());

  task print_verdict;
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'h2, w, a, d};
    @(posedge clk);
    pen <= 1;
    // ready, read data and error are all taken at the completing rising edge
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    er = perr;
    {psel, pen} <= 2'h0;
    if (prdy !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : apb

  // pass point: clock running on the slow oscillator, ports driven
  task wait_fetch;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vf !== 1'b1 && n < 400);
    chk("clken", 1, clken);
    chk("onslow", 1, onslow);
    chk("hiz", 0, hiz);
    if (vf !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_fetch

  task probe(input logic s);
    @(posedge clk);
    stop <= s;
    fork
      sup_u.fire(3, 12);
      begin
        repeat (6) @(negedge clk);
        chk("standby", s, sb);
        chk("init", !s, pinit);
        chk("held", 0, clken);
        chk("sysn", 0, sysn);
      end
    join
    wait_fetch();
    @(posedge clk);
    stop <= 0;
  endtask : probe

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    wait_fetch();
    apb(0, 12'h008, 0);
    chk("settle", 32'h05, rd);
    apb(0, 12'h020, 0);
    chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    foreach (rows[i]) begin
      apb(1, 12'h004, 32'h5a);
      sup_u.fire(int'(rows[i].src), 4);
      wait_fetch();
      if (rows[i].rd) begin
        apb(0, 12'h000, 0);
        chk("cause", {24'h0, rows[i].cause}, rd);
      end
      apb(0, 12'h004, 0);
      chk("lvdset", {24'h0, rows[i].lvd}, rd);
      chk("lvdout", {24'h0, rows[i].lvd}, {24'h0, lvdo});
    end
    apb(0, 12'h000, 0);
    chk("cause", 0, rd);
    probe(0);
    probe(1);
    // clock switch and settle select, then a block reset in mid-run
    apb(1, 12'h00c, 32'h1);
    apb(1, 12'h008, 32'h3);
    @(negedge clk);
    chk("onslow", 0, onslow);
    chk("settle", 32'h03, {24'h0, settle});
    apb(0, 12'h010, 0);
    chk("status", 0, rd & 32'h83);
    @(posedge clk);
    rst_n <= 0;
    repeat (3) @(negedge clk);
    chk("onslow", 1, onslow);
    chk("settle", 32'h05, {24'h0, settle});
    chk("lvdout", 0, {24'h0, lvdo});
    chk("sysn", 0, sysn);
    chk("hiz", 1, hiz);
    @(posedge clk);
    rst_n <= 1;
    wait_fetch();
    print_verdict();
  end
endmodule : rsc_reset_source_controller_tb

`default_nettype wire
